/* File: src/ohp_pkg.sv */
// Shared constants, types and helpers for the OLED host pin front end
package ohp_pkg;
  // Strap codes seen on bus_mode_pins
  localparam logic [2:0] BS_SERIAL = 3'h0;
  localparam logic [2:0] BS_TWI = 3'h1;
  localparam logic [2:0] BS_E4 = 3'h2;
  localparam logic [2:0] BS_RW4 = 3'h3;
  localparam logic [2:0] BS_E8 = 3'h6;
  localparam logic [2:0] BS_RW8 = 3'h7;
  localparam logic [2:0] MODE_RST = BS_E8;
  localparam int DATA_W = 8;
  localparam int SEG_N = 100;
  localparam int COM_N = 32;
  localparam int CLK_MHZ = 125;
  // Host bus timing, least times in ns, rounded up to cycles
  localparam int SETUP_NS = 24;
  localparam int STROBE_NS = 80;
  localparam int HOLD_NS = 40;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] OE_BYTE = 8'hFF;
  localparam logic [7:0] OE_HI_NIB = 8'hF0;
  localparam logic [2:0] OE_SER_OUT = 3'h4;

  typedef enum logic [4:0] {
    OHP_IDLE = 5'h01,
    OHP_SETUP = 5'h02,
    OHP_ACT = 5'h04,
    OHP_HOLD = 5'h08,
    OHP_DONE = 5'h10
  } ohp_hstate_t;

  function automatic logic [3:0] ohp_nib(input logic [7:0] b,
                                         input logic hi);
    ohp_nib = hi ? b[7:4] : b[3:0];
  endfunction : ohp_nib

  function automatic logic ohp_four(input logic [2:0] m);
    ohp_four = (m == BS_E4) || (m == BS_RW4);
  endfunction : ohp_four
endpackage : ohp_pkg

/* File: src/ohp_if.sv */
// Pin bundle joining host and device ends
`timescale 1ns/100ps
interface ohp_if;
  logic cs_n;
  logic init_in_n;
  logic data_cmd_sel;
  logic rd_wr_sel;
  logic bus_strobe;
  logic osc_select;
  logic ext_clk_in;
  logic frame_sync_out;
  logic [2:0] bus_mode_pins;
  logic [7:0] host_d_o;
  logic [7:0] host_d_oe;
  logic [7:0] dev_d_o;
  logic [7:0] dev_d_oe;
  logic [7:0] d_bus;

  // Undriven pins read low, as if tied to ground
  genvar i;
  for (i = 0; i < 8; i++) begin : g_res
    assign d_bus[i] = dev_d_oe[i] ? dev_d_o[i] :
                      (host_d_oe[i] ? host_d_o[i] : 1'b0);
  end

  modport dev (
    input cs_n, init_in_n, data_cmd_sel, rd_wr_sel, bus_strobe,
    input osc_select, ext_clk_in, bus_mode_pins, d_bus,
    output dev_d_o, dev_d_oe, frame_sync_out
  );
  modport host (
    output cs_n, init_in_n, data_cmd_sel, rd_wr_sel, bus_strobe,
    output osc_select, ext_clk_in, bus_mode_pins, host_d_o, host_d_oe,
    input d_bus, frame_sync_out
  );
endinterface : ohp_if

/* File: src/ohp_sync.sv */
// Two-flop synchroniser for a group of levels
`timescale 1ns/100ps
module ohp_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : ohp_sync

/* File: src/ohp_dev.sv */
// Device end: pin front end of the character OLED controller
`timescale 1ns/100ps
module ohp_dev #(
  parameter int SEG_N = ohp_pkg::SEG_N,
  parameter int COM_N = ohp_pkg::COM_N
) (
  input wire logic clk,
  input wire logic rst,
  ohp_if.dev bus,
  input wire logic [7:0] rd_byte,
  input wire logic serial_dout,
  input wire logic twi_sda_out,
  input wire logic frame_tick,
  input wire logic display_on,
  input wire logic [SEG_N-1:0] seg_pattern,
  input wire logic [COM_N-1:0] com_pattern,
  output logic data_wr_valid,
  output logic cmd_wr_valid,
  output logic [7:0] wr_byte,
  output logic rd_req,
  output logic rd_is_data,
  output logic core_init,
  output logic [2:0] mode,
  output logic serial_clk_in,
  output logic serial_din,
  output logic addr_select_bit,
  output logic ext_clk_sel,
  output logic ext_clk_tick,
  output logic [SEG_N-1:0] segment_drive,
  output logic [COM_N-1:0] common_drive_o,
  output logic [COM_N-1:0] common_drive_oe
);
  if (SEG_N < 1 || COM_N < 1) begin : g_chk
    $error("ohp_dev: driver counts must be positive");
  end

  logic s_cs_n, s_init_n, s_dc, s_rw, s_stb, s_osc, s_ext;
  logic [2:0] s_mode;
  logic [7:0] s_d;
  logic p_rw_q, p_stb_q, p_ext_q;
  logic mode_done_q, nib_q, wr_act_q, rd_act_q;
  logic [3:0] hi_q;
  logic [7:0] rd_hold_q, dout_q, doe_q;

  ohp_sync #(.W(18), .RST_VAL(18'h30000)) u_sync (
    .clk(clk),
    .rst(rst),
    .din({bus.init_in_n, bus.cs_n, bus.data_cmd_sel, bus.rd_wr_sel,
          bus.bus_strobe, bus.osc_select, bus.ext_clk_in,
          bus.bus_mode_pins, bus.d_bus}),
    .dout({s_init_n, s_cs_n, s_dc, s_rw, s_stb, s_osc, s_ext,
           s_mode, s_d})
  );

  wire core_rst = rst | ~s_init_n;
  wire m_en = (mode == ohp_pkg::BS_E8) || (mode == ohp_pkg::BS_E4);
  wire m_sep = (mode == ohp_pkg::BS_RW8) || (mode == ohp_pkg::BS_RW4);
  wire m_four = ohp_pkg::ohp_four(mode);
  wire m_ser = mode == ohp_pkg::BS_SERIAL;
  wire m_twi = mode == ohp_pkg::BS_TWI;
  wire sel = ~s_cs_n;
  wire stb_rise = s_stb & ~p_stb_q;
  wire stb_fall = ~s_stb & p_stb_q;
  wire rw_rise = s_rw & ~p_rw_q;
  wire rw_fall = ~s_rw & p_rw_q;
  wire en_start = m_en & sel & stb_rise;
  wire en_rd_start = en_start & s_rw;
  wire en_wr_cap = m_en & sel & stb_fall & ~s_rw & ~rd_act_q;
  // write begins on falling write strobe
  wire sep_wr_start = m_sep & sel & rw_fall;
  wire sep_wr_cap = m_sep & sel & rw_rise & wr_act_q;
  // read begins on falling read strobe
  wire sep_rd_start = m_sep & sel & stb_fall;
  wire rd_start = en_rd_start | sep_rd_start;
  wire rd_end = rd_act_q & ((m_en & stb_fall) | (m_sep & stb_rise));
  wire wr_cap = en_wr_cap | sep_wr_cap;
  wire wr_done = wr_cap & (~m_four | nib_q);
  wire [7:0] wr_val = m_four ? {hi_q, s_d[7:4]} : s_d;
  wire first_rd = rd_start & (~m_four | ~nib_q);
  wire [7:0] rd_src = first_rd ? rd_byte : rd_hold_q;
  wire [7:0] rd_out = m_four ?
    {ohp_pkg::ohp_nib(rd_src, ~nib_q), 4'h0} : rd_src;

  // mode taken once from straps after reset
  always_ff @(posedge clk) begin
    if (core_rst) begin
      mode <= ohp_pkg::MODE_RST;
      mode_done_q <= 1'b0;
    end else if (!mode_done_q) begin
      mode <= s_mode;
      mode_done_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      p_rw_q <= 1'b0;
      p_stb_q <= 1'b0;
      p_ext_q <= 1'b0;
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      nib_q <= 1'b0;
      hi_q <= 4'h0;
      rd_hold_q <= ohp_pkg::BYTE_RST;
    end else begin
      p_rw_q <= s_rw;
      p_stb_q <= s_stb;
      p_ext_q <= s_ext;
      wr_act_q <= sel & (sep_wr_start | (wr_act_q & ~sep_wr_cap));
      rd_act_q <= sel & (rd_start | (rd_act_q & ~rd_end));
      if (first_rd) begin
        rd_hold_q <= rd_byte;
      end
      // nibble phase; deselect restarts at high nibble
      if (!sel || !m_four) begin
        nib_q <= 1'b0;
      end else if (wr_cap || rd_end) begin
        nib_q <= ~nib_q;
      end
      if (wr_cap && !nib_q) begin
        hi_q <= s_d[7:4];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      data_wr_valid <= 1'b0;
      cmd_wr_valid <= 1'b0;
      wr_byte <= ohp_pkg::BYTE_RST;
      rd_req <= 1'b0;
      rd_is_data <= 1'b0;
    end else begin
      data_wr_valid <= wr_done & s_dc;
      cmd_wr_valid <= wr_done & ~s_dc;
      if (wr_done) begin
        wr_byte <= wr_val;
      end
      rd_req <= first_rd;
      if (first_rd) begin
        rd_is_data <= s_dc;
      end
    end
  end

  // drive only during a selected read; serial outputs
  always_ff @(posedge clk) begin
    if (core_rst) begin
      dout_q <= ohp_pkg::BYTE_RST;
      doe_q <= 8'h00;
    end else if (m_ser && sel) begin
      dout_q <= {5'h00, serial_dout, 2'h0};
      doe_q <= {5'h00, ohp_pkg::OE_SER_OUT};
    end else if (m_twi) begin
      // Open drain: only pull low, the line idles released
      dout_q <= ohp_pkg::BYTE_RST;
      doe_q <= {5'h00, ~twi_sda_out, 2'h0};
    end else if (rd_start) begin
      dout_q <= rd_out;
      doe_q <= m_four ? ohp_pkg::OE_HI_NIB : ohp_pkg::OE_BYTE;
    end else if (rd_end || !sel) begin
      doe_q <= 8'h00;
    end
  end

  assign bus.dev_d_o = dout_q;
  assign bus.dev_d_oe = doe_q;

  // pin reuse toward the serial engines
  always_ff @(posedge clk) begin
    if (core_rst) begin
      serial_clk_in <= 1'b0;
      serial_din <= 1'b0;
      addr_select_bit <= 1'b0;
      ext_clk_sel <= 1'b0;
      ext_clk_tick <= 1'b0;
      core_init <= 1'b1;
    end else begin
      serial_clk_in <= (m_ser & sel | m_twi) & s_d[0];
      serial_din <= (m_ser & sel | m_twi) & s_d[1];
      addr_select_bit <= m_twi & s_dc;
      // external clock taken on its sampled rising edge
      ext_clk_sel <= ~s_osc;
      ext_clk_tick <= ~s_osc & s_ext & ~p_ext_q;
      core_init <= 1'b0;
    end
  end

  logic fr_q;
  always_ff @(posedge clk) begin
    if (core_rst) begin
      fr_q <= 1'b0;
    end else begin
      fr_q <= frame_tick;
    end
  end
  assign bus.frame_sync_out = fr_q;

  // panel off state; off through reset
  always_ff @(posedge clk) begin
    if (core_rst) begin
      segment_drive <= '0;
      common_drive_o <= '0;
      common_drive_oe <= '0;
    end else begin
      segment_drive <= display_on ? seg_pattern : '0;
      common_drive_o <= com_pattern;
      common_drive_oe <= display_on ? '1 : '0;
    end
  end
endmodule : ohp_dev

/* File: src/ohp_host.sv */
// Host end: parallel bus master of the OLED pin front end
`timescale 1ns/100ps
module ohp_host (
  input wire logic clk,
  input wire logic rst,
  ohp_if.host bus,
  input wire logic [2:0] mode_sel,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_dc,
  input wire logic [7:0] req_data,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic frame_sync
);
  ohp_pkg::ohp_hstate_t st_q;
  logic [3:0] cnt_q;
  logic wr_q, dc_q, nib_q, cs_n_q, init_n_q, rw_q, stb_q;
  logic [7:0] dat_q, oe_q, rd_q;
  logic [2:0] mode_q;

  wire m_en = (mode_q == ohp_pkg::BS_E8) || (mode_q == ohp_pkg::BS_E4);
  wire m_sep = (mode_q == ohp_pkg::BS_RW8) || (mode_q == ohp_pkg::BS_RW4);
  wire m_four = ohp_pkg::ohp_four(mode_q);
  wire par = m_en | m_sep;
  // serial modes park every strobe low; separate mode idles high
  wire rw_idle = m_sep;
  wire stb_idle = m_sep;
  wire rw_act = ~wr_q;
  wire stb_act = m_en ? 1'b1 : wr_q;
  wire cs_idle = mode_q != ohp_pkg::BS_TWI;
  wire [7:0] out_byte = m_four ?
    {ohp_pkg::ohp_nib(dat_q, ~nib_q), 4'h0} : dat_q;
  wire cnt_end = cnt_q == 4'h1;
  wire take = (st_q == ohp_pkg::OHP_IDLE) & req_valid & par;

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= ohp_pkg::OHP_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      dc_q <= 1'b0;
      nib_q <= 1'b0;
      dat_q <= ohp_pkg::BYTE_RST;
      rd_q <= ohp_pkg::BYTE_RST;
      mode_q <= ohp_pkg::MODE_RST;
      init_n_q <= 1'b0;
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      // hold the device in init only while reset
      init_n_q <= 1'b1;
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      cnt_q <= cnt_end ? 4'h0 : cnt_q - 4'h1;
      case (st_q)
        ohp_pkg::OHP_IDLE: begin
          mode_q <= mode_sel;
          req_ready <= par & ~req_valid;
          if (take) begin
            wr_q <= req_write;
            dc_q <= req_dc;
            dat_q <= req_data;
            nib_q <= 1'b0;
            cnt_q <= 4'(ohp_pkg::SETUP_CYC);
            st_q <= ohp_pkg::OHP_SETUP;
          end
        end
        ohp_pkg::OHP_SETUP: begin
          if (cnt_end) begin
            cnt_q <= 4'(ohp_pkg::STROBE_CYC);
            st_q <= ohp_pkg::OHP_ACT;
          end
        end
        ohp_pkg::OHP_ACT: begin
          if (cnt_end) begin
            // Sample before the closing edge, device still driving
            if (m_four && !nib_q) begin
              rd_q[7:4] <= bus.d_bus[7:4];
            end else if (m_four) begin
              rd_q[3:0] <= bus.d_bus[7:4];
            end else begin
              rd_q <= bus.d_bus;
            end
            cnt_q <= 4'(ohp_pkg::HOLD_CYC);
            st_q <= ohp_pkg::OHP_HOLD;
          end
        end
        ohp_pkg::OHP_HOLD: begin
          if (cnt_end) begin
            st_q <= ohp_pkg::OHP_DONE;
          end
        end
        ohp_pkg::OHP_DONE: begin
          if (m_four && !nib_q) begin
            nib_q <= 1'b1;
            cnt_q <= 4'(ohp_pkg::SETUP_CYC);
            st_q <= ohp_pkg::OHP_SETUP;
          end else begin
            rsp_valid <= ~wr_q;
            st_q <= ohp_pkg::OHP_IDLE;
          end
        end
        default: st_q <= ohp_pkg::OHP_IDLE;
      endcase
    end
  end

  wire busy = st_q != ohp_pkg::OHP_IDLE;
  wire in_act = st_q == ohp_pkg::OHP_ACT;
  wire drive = busy & wr_q & (st_q != ohp_pkg::OHP_DONE);

  // Pins registered; cs grounded in two-wire mode
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_n_q <= 1'b1;
      rw_q <= 1'b0;
      stb_q <= 1'b0;
      oe_q <= 8'h00;
      frame_sync <= 1'b0;
    end else begin
      cs_n_q <= busy ? 1'b0 : cs_idle;
      rw_q <= in_act && m_sep ? rw_act : (m_en ? ~wr_q & busy : rw_idle);
      stb_q <= in_act ? (m_en ? stb_act : wr_q) : stb_idle;
      // drive only the lanes in use
      oe_q <= drive ? (m_four ? ohp_pkg::OE_HI_NIB : ohp_pkg::OE_BYTE)
                    : 8'h00;
      frame_sync <= bus.frame_sync_out;
    end
  end

  assign rsp_data = rd_q;
  assign bus.cs_n = cs_n_q;
  assign bus.init_in_n = init_n_q;
  assign bus.data_cmd_sel = par & dc_q;
  assign bus.rd_wr_sel = rw_q;
  assign bus.bus_strobe = stb_q;
  assign bus.host_d_o = out_byte;
  assign bus.host_d_oe = oe_q;
  assign bus.bus_mode_pins = mode_q;
  // internal oscillator used; external clock pin grounded
  assign bus.osc_select = 1'b1;
  assign bus.ext_clk_in = 1'b0;
endmodule : ohp_host

/* File: verification/ohp_checker.sv */
// Pin checker for the OLED host pin front end
`timescale 1ns/100ps
module ohp_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic rd_wr_sel,
  input wire logic bus_strobe,
  input wire logic [2:0] bus_mode_pins,
  input wire logic [7:0] host_d_oe,
  input wire logic [7:0] dev_d_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire e8 = bus_mode_pins == ohp_pkg::BS_E8;
  wire s8 = bus_mode_pins == ohp_pkg::BS_RW8;
  wire e4 = bus_mode_pins == ohp_pkg::BS_E4;
  logic stb_p_q;
  // Strobe history kept in a flop so the start term stays a plain wire
  always_ff @(posedge clk) begin
    if (rst) begin
      stb_p_q <= 1'b0;
    end else begin
      stb_p_q <= bus_strobe;
    end
  end
  wire go = bus_strobe && !stb_p_q && !cs_n && rd_wr_sel;
  property p_fight;
    (host_d_oe & dev_d_oe) == 8'h00;
  endproperty
  a_fight: assert property (p_fight)
    else $error("both ends drive the data bus");
  property p_sel;
    $rose(|dev_d_oe) |-> $past(cs_n, 2) == 1'b0;
  endproperty
  a_sel: assert property (p_sel)
    else $error("device drove while deselected");
  property p_rel;
    cs_n [*6] |-> dev_d_oe == 8'h00;
  endproperty
  a_rel: assert property (p_rel)
    else $error("device holds bus with select high");
  property p_rd8;
    e8 && go |-> ##[2:4] dev_d_oe == 8'hFF;
  endproperty
  a_rd8: assert property (p_rd8)
    else $error("no read drive in enable mode");
  property p_wr8;
    e8 && !cs_n && !rd_wr_sel && bus_strobe |-> dev_d_oe == 8'h00;
  endproperty
  a_wr8: assert property (p_wr8)
    else $error("device drove during a write");
  property p_rds;
    s8 && $fell(bus_strobe) && !cs_n |-> ##[2:4] dev_d_oe == 8'hFF;
  endproperty
  a_rds: assert property (p_rds)
    else $error("no read drive in separate mode");
  property p_wrs;
    s8 && !cs_n && !rd_wr_sel |-> dev_d_oe == 8'h00;
  endproperty
  a_wrs: assert property (p_wrs)
    else $error("device drove during write strobe");
  property p_rd4;
    e4 && go |-> ##[2:4] dev_d_oe == 8'hF0;
  endproperty
  a_rd4: assert property (p_rd4)
    else $error("four-bit read drive wrong");
  c_rd8: cover property (e8 && go);
  c_wr8: cover property (e8 && $fell(bus_strobe) && !cs_n && !rd_wr_sel);
  c_rds: cover property (s8 && $fell(bus_strobe) && !cs_n);
  c_rd4: cover property (e4 && go);
endmodule : ohp_checker

/* File: verification/tb_top.sv */
// Self-checking bench joining host and device ends
`timescale 1ns/100ps
module tb_top;
  localparam int LIMIT = 6000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] mode_sel = ohp_pkg::BS_E8;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_dc = 1'b0;
  logic [7:0] req_data = 8'h00;
  logic [7:0] rd_byte = 8'h00;
  logic frame_tick = 1'b0;
  logic display_on = 1'b0;
  logic [ohp_pkg::SEG_N-1:0] seg_pattern = '1;
  logic [ohp_pkg::COM_N-1:0] com_pattern = '1;
  logic req_ready, rsp_valid, frame_sync, data_wr_valid, cmd_wr_valid;
  logic rd_is_data, core_init;
  logic [7:0] rsp_data, wr_byte;
  logic [2:0] dev_mode;
  logic [ohp_pkg::SEG_N-1:0] segment_drive;
  logic [ohp_pkg::COM_N-1:0] common_drive_oe;
  logic [ohp_pkg::COM_N-1:0] common_drive_o;
  logic rd_req, ext_clk_sel, addr_select_bit;
  logic sda_out = 1'b1;
  int n_rd = 0;
  int n_wr = 0;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  ohp_if bus_if();
  ohp_dev i_ohp_dev (.clk(clk), .rst(rst), .bus(bus_if),
    .rd_byte(rd_byte), .serial_dout(1'b1), .twi_sda_out(sda_out),
    .frame_tick(frame_tick), .display_on(display_on),
    .seg_pattern(seg_pattern), .com_pattern(com_pattern),
    .data_wr_valid(data_wr_valid), .cmd_wr_valid(cmd_wr_valid),
    .wr_byte(wr_byte), .rd_req(rd_req), .rd_is_data(rd_is_data),
    .core_init(core_init), .mode(dev_mode), .serial_clk_in(),
    .serial_din(), .addr_select_bit(addr_select_bit),
    .ext_clk_sel(ext_clk_sel),
    .ext_clk_tick(), .segment_drive(segment_drive),
    .common_drive_o(common_drive_o),
    .common_drive_oe(common_drive_oe));
  ohp_host i_ohp_host (.clk(clk), .rst(rst), .bus(bus_if),
    .mode_sel(mode_sel), .req_valid(req_valid), .req_write(req_write),
    .req_dc(req_dc), .req_data(req_data), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .frame_sync(frame_sync));
  ohp_checker i_ohp_checker (.clk(clk), .rst(rst), .cs_n(bus_if.cs_n),
    .rd_wr_sel(bus_if.rd_wr_sel), .bus_strobe(bus_if.bus_strobe),
    .bus_mode_pins(bus_if.bus_mode_pins),
    .host_d_oe(bus_if.host_d_oe), .dev_d_oe(bus_if.dev_d_oe));

  always #4 clk = ~clk;

  // Pulses counted away from the edge that launches them
  always @(negedge clk) begin
    if (rd_req === 1'b1) begin
      n_rd++;
    end
    if ((data_wr_valid | cmd_wr_valid) === 1'b1) begin
      n_wr++;
    end
  end

  task automatic results();
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // A hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      results();
    end
  end

  task automatic check(input logic [99:0] seen, input logic [99:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Straps only change under reset, as the device takes them once
  task automatic do_reset(input logic [2:0] m);
    rst = 1'b1;
    mode_sel = m;
    repeat (6) @(posedge clk);
    #1;
    check(core_init, 1'b1);
    check(segment_drive, '0);
    check(common_drive_oe, '0);
    rst = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check(dev_mode, m);
    check(core_init, 1'b0);
  endtask : do_reset

  task automatic xfer(input logic wr, input logic dc, input logic [7:0] d);
    int k;
    int rd0;
    int wr0;
    k = 0;
    rd_byte = d;
    // At least one idle cycle between requests
    repeat (2) @(posedge clk);
    #1;
    while (req_ready !== 1'b1 && k < 100) begin
      @(posedge clk);
      #1;
      k++;
    end
    rd0 = n_rd;
    wr0 = n_wr;
    req_valid = 1'b1;
    req_write = wr;
    req_dc = dc;
    req_data = d;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    k = 0;
    while (k < 100 &&
           (wr ? (data_wr_valid | cmd_wr_valid) : rsp_valid) !== 1'b1) begin
      @(posedge clk);
      #1;
      k++;
    end
    check(k < 100, 1'b1);
    if (wr) begin
      check(data_wr_valid, dc);
      check(cmd_wr_valid, !dc);
      check(wr_byte, d);
      check(n_rd - rd0, 0);
    end else begin
      check(rsp_data, d);
      check(rd_is_data, dc);
      check(n_rd - rd0, 1);
      check(n_wr - wr0, 0);
    end
  endtask : xfer

  initial begin
    logic [2:0] modes [4];
    modes = '{ohp_pkg::BS_E8, ohp_pkg::BS_RW8, ohp_pkg::BS_E4,
              ohp_pkg::BS_RW4};
    for (int i = 0; i < 4; i++) begin
      do_reset(modes[i]);
      xfer(1'b1, 1'b1, 8'hA5);
      xfer(1'b1, 1'b0, 8'h3C);
      xfer(1'b0, 1'b1, 8'h96);
      xfer(1'b0, 1'b0, 8'h0F);
    end
    @(posedge clk);
    #1;
    frame_tick = 1'b1;
    @(posedge clk);
    #1;
    frame_tick = 1'b0;
    check(bus_if.frame_sync_out, 1'b1);
    @(posedge clk);
    #1;
    check(frame_sync, 1'b1);
    check(bus_if.frame_sync_out, 1'b0);
    display_on = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check(segment_drive, seg_pattern);
    check(common_drive_oe, {ohp_pkg::COM_N{1'b1}});
    check(common_drive_o, com_pattern);
    display_on = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(segment_drive, '0);
    check(common_drive_oe, '0);
    // Serial straps: host refuses parallel requests
    do_reset(ohp_pkg::BS_SERIAL);
    check(req_ready, 1'b0);
    check(bus_if.bus_strobe, 1'b0);
    check(bus_if.rd_wr_sel, 1'b0);
    check(bus_if.dev_d_oe, 8'h00);
    // Two-wire straps: select grounded, open-drain data line
    do_reset(ohp_pkg::BS_TWI);
    check(bus_if.cs_n, 1'b0);
    check(req_ready, 1'b0);
    check(addr_select_bit, 1'b0);
    check(ext_clk_sel, 1'b0);
    check(bus_if.dev_d_oe, 8'h00);
    sda_out = 1'b0;
    @(posedge clk);
    #1;
    check(bus_if.dev_d_oe, 8'h04);
    check(bus_if.dev_d_o[2], 1'b0);
    sda_out = 1'b1;
    results();
  end
endmodule : tb_top
